// >>> verilog/cvio_pkg.sv
// Purpose: Shared constants for the converter pin and reset block
// Assumes: ref_clk at 200 MHz
// Notes: Serial frame is 8 bits, msb first
package cvio_pkg;
   localparam int unsigned CVIO_FRAME_BITS = 8;
   localparam logic [2:0] CVIO_BIT_CNT_RST = 3'h0;
   localparam logic [7:0] CVIO_BYTE_RST = 8'h00;
   localparam logic [2:0] CVIO_ADDR_IOPORT = 3'h1;
   localparam logic [2:0] CVIO_ADDR_AUX = 3'h2;
   localparam logic [7:0] CVIO_IOPORT_RST = 8'h00;
   localparam logic [7:0] CVIO_AUX_RST = 8'h00;
   // I/O port register fields
   localparam int unsigned CVIO_P0_VAL = 7;
   localparam int unsigned CVIO_P1_VAL = 6;
   localparam int unsigned CVIO_PORT_PIN_ZERO_DIRECTION = 5;
   localparam int unsigned CVIO_PORT_PIN_ONE_DIRECTION = 4;
   localparam int unsigned CVIO_SYNC_EN = 0;
   // Aux register and command byte fields
   localparam int unsigned CVIO_MCO_OFF = 0;
   localparam int unsigned CVIO_CMD_READ = 6;
   typedef enum logic [1:0] {CVIO_ST_CMD, CVIO_ST_DATA} cvio_state_e;
endpackage

// >>> verilog/cvio_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input asynchronous to ref_clk
// Notes: First stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module cvio_sync2 (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic rst_val,
   input wire logic async_in,
   output logic sync_out
);
   logic meta;
   logic next_meta;
   logic next_out;
   always_comb begin
      next_meta = rst ? rst_val : async_in;
      next_out = rst ? rst_val : meta;
   end
   always_ff @(posedge ref_clk) begin
      meta <= next_meta;
      sync_out <= next_out;
   end
endmodule
`default_nettype wire

// >>> verilog/cvio_top.sv
// Purpose: Reset, chip select framing, serial register access and port pins
// Assumes: Host serial clock sampled by ref_clk, at most ref_clk/8
// Notes: Data sampled on rising, shifted out on falling serial clock
// Contract
// - Reset low clears all logic and registers; the clock output keeps following the master clock input
// - Chip select tied low gives three-wire mode
// - Chip select frames each 8-bit transfer
// - Pin zero direction and value bits
// - Pin one direction and value bits
// - Sync enable makes pin one an input
// - Clock output inverted or switched off
// - Data goes to addressed register
`timescale 1ns/100ps
`default_nettype none
module cvio_top (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reset_n,
   input wire logic serial_clock,
   input wire logic chip_select_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   input wire logic master_clock_input,
   output logic master_clock_output,
   input wire logic port_pin_zero_in,
   output logic port_pin_zero_out,
   output logic port_pin_zero_oe,
   input wire logic align_or_port_pin_one_in,
   output logic port_pin_one_out,
   output logic port_pin_one_oe,
   output logic align_pulse,
   output logic logic_reset
);
   logic sclk_s, cs_n_s, din_s, rstn_s, mclk_s, p0_s, p1_s;
   logic sclk_d;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] shift_in, next_shift_in;
   logic [7:0] shift_out, next_shift_out;
   logic [2:0] addr, next_addr;
   logic [7:0] io_reg, next_io_reg;
   logic [7:0] aux_reg, next_aux_reg;
   cvio_pkg::cvio_state_e state, next_state;
   logic next_dout, next_mco, next_p0_out, next_p0_oe, next_p1_out, next_p1_oe;
   logic next_align, next_lrst;
   logic cmd_read, next_cmd_read;
   logic rise, fall, frame_rst, any_rst;
   logic [7:0] done_byte;

   // Every outside pin passes two flops
   // Reset to the idle level so no false edge follows reset
   cvio_sync2 u_sclk (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b1),
      .async_in(serial_clock), .sync_out(sclk_s));
   cvio_sync2 u_cs (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b1),
      .async_in(chip_select_n), .sync_out(cs_n_s));
   cvio_sync2 u_din (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b0),
      .async_in(serial_data_in), .sync_out(din_s));
   cvio_sync2 u_rstn (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b0),
      .async_in(reset_n), .sync_out(rstn_s));
   cvio_sync2 u_mclk (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b0),
      .async_in(master_clock_input), .sync_out(mclk_s));
   cvio_sync2 u_p0 (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b0),
      .async_in(port_pin_zero_in), .sync_out(p0_s));
   cvio_sync2 u_p1 (.ref_clk(ref_clk), .rst(rst), .rst_val(1'b0),
      .async_in(align_or_port_pin_one_in), .sync_out(p1_s));

   function automatic logic [7:0] read_reg(input logic [2:0] a,
         input logic [7:0] io, input logic [7:0] aux, input logic i0, input logic i1);
      logic [7:0] v;
      v = 8'h00;
      if (a == cvio_pkg::CVIO_ADDR_IOPORT) begin
         v = io;
         // Inputs report the pin, outputs the stored value
         if (!io[cvio_pkg::CVIO_PORT_PIN_ZERO_DIRECTION]) v[cvio_pkg::CVIO_P0_VAL] = i0;
         if (!io[cvio_pkg::CVIO_PORT_PIN_ONE_DIRECTION]) v[cvio_pkg::CVIO_P1_VAL] = i1;
      end else if (a == cvio_pkg::CVIO_ADDR_AUX) begin
         v = aux;
      end
      return v;
   endfunction

   assign any_rst = rst || !rstn_s;
   // Chip select high aborts a partial byte; tied low never does
   assign frame_rst = any_rst || cs_n_s;
   assign rise = sclk_s && !sclk_d && !cs_n_s;
   assign fall = !sclk_s && sclk_d && !cs_n_s;
   assign done_byte = {shift_in[6:0], din_s};

   always_comb begin
      next_bit_cnt = bit_cnt;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_state = state;
      next_addr = addr;
      next_io_reg = io_reg;
      next_aux_reg = aux_reg;
      next_dout = serial_data_out;
      if (rise) begin
         next_shift_in = done_byte;
         next_bit_cnt = bit_cnt + 3'h1;
         if (bit_cnt == 3'h7) begin
            unique case (state)
               cvio_pkg::CVIO_ST_CMD: begin
                  next_addr = done_byte[2:0];
                  next_state = cvio_pkg::CVIO_ST_DATA;
                  next_shift_out = read_reg(done_byte[2:0], io_reg, aux_reg, p0_s, p1_s);
               end
               cvio_pkg::CVIO_ST_DATA: begin
                  next_state = cvio_pkg::CVIO_ST_CMD;
                  next_shift_out = cvio_pkg::CVIO_BYTE_RST;
                  if (!cmd_read) begin
                     if (addr == cvio_pkg::CVIO_ADDR_IOPORT) next_io_reg = done_byte;
                     if (addr == cvio_pkg::CVIO_ADDR_AUX) next_aux_reg = done_byte;
                  end
               end
               default: next_state = cvio_pkg::CVIO_ST_CMD;
            endcase
         end
      end
      if (fall) begin
         next_dout = shift_out[7];
         next_shift_out = {shift_out[6:0], 1'b0};
      end
      if (frame_rst) begin
         next_bit_cnt = cvio_pkg::CVIO_BIT_CNT_RST;
         next_shift_in = cvio_pkg::CVIO_BYTE_RST;
         next_dout = 1'b0;
      end
      if (any_rst) begin
         next_state = cvio_pkg::CVIO_ST_CMD;
         next_addr = 3'h0;
         next_shift_out = cvio_pkg::CVIO_BYTE_RST;
         next_io_reg = cvio_pkg::CVIO_IOPORT_RST;
         next_aux_reg = cvio_pkg::CVIO_AUX_RST;
      end
   end

   // Read flag of the command byte keeps the data byte from writing

   always_comb begin
      next_cmd_read = cmd_read;
      if (rise && bit_cnt == 3'h7 && state == cvio_pkg::CVIO_ST_CMD)
         next_cmd_read = done_byte[cvio_pkg::CVIO_CMD_READ];
      if (any_rst) next_cmd_read = 1'b0;
   end

   always_comb begin
      // Sync use forces pin one to input
      next_p0_oe = io_reg[cvio_pkg::CVIO_PORT_PIN_ZERO_DIRECTION];
      next_p0_out = io_reg[cvio_pkg::CVIO_P0_VAL];
      next_p1_oe = io_reg[cvio_pkg::CVIO_PORT_PIN_ONE_DIRECTION] && !io_reg[cvio_pkg::CVIO_SYNC_EN];
      next_p1_out = io_reg[cvio_pkg::CVIO_P1_VAL];
      // Low level on the align pin holds modulator and filter
      next_align = io_reg[cvio_pkg::CVIO_SYNC_EN] && !p1_s;
      // Oscillator keeps running through reset_n low; rst holds the output high
      next_mco = aux_reg[cvio_pkg::CVIO_MCO_OFF] ? 1'b0 : !mclk_s;
      next_lrst = any_rst;
      if (any_rst) begin
         next_p0_oe = 1'b0;
         next_p1_oe = 1'b0;
         next_p0_out = 1'b0;
         next_p1_out = 1'b0;
         next_align = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      sclk_d <= sclk_s;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      state <= next_state;
      addr <= next_addr;
      io_reg <= next_io_reg;
      aux_reg <= next_aux_reg;
      serial_data_out <= next_dout;
      cmd_read <= next_cmd_read;
      port_pin_zero_oe <= next_p0_oe;
      port_pin_zero_out <= next_p0_out;
      port_pin_one_oe <= next_p1_oe;
      port_pin_one_out <= next_p1_out;
      align_pulse <= next_align;
      master_clock_output <= next_mco;
      logic_reset <= next_lrst;
   end

   AST_P1_INPUT_IN_SYNC: assert property (@(posedge ref_clk) disable iff (rst)
      io_reg[cvio_pkg::CVIO_SYNC_EN] |=> !port_pin_one_oe)
      else $error("pin one driven while sync enabled");
   AST_RESET_CLEARS_REGS: assert property (@(posedge ref_clk) disable iff (rst)
      !rstn_s |=> io_reg == 8'h00 && aux_reg == 8'h00 && bit_cnt == 3'h0)
      else $error("registers not cleared by reset pin");
   AST_RESET_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
      !rstn_s |=> logic_reset)
      else $error("reset output missing");
   AST_CS_HIGH_ABORTS: assert property (@(posedge ref_clk) disable iff (rst)
      cs_n_s |=> bit_cnt == 3'h0)
      else $error("frame not aborted by chip select");
   AST_PORT_PIN_ZERO_DIRECTION: assert property (@(posedge ref_clk) disable iff (rst)
      rstn_s && $past(rstn_s) |=> port_pin_zero_oe == $past(io_reg[cvio_pkg::CVIO_PORT_PIN_ZERO_DIRECTION]))
      else $error("pin zero direction mismatch");
   AST_P0_VALUE: assert property (@(posedge ref_clk) disable iff (rst)
      !any_rst |=> port_pin_zero_out == $past(io_reg[cvio_pkg::CVIO_P0_VAL]))
      else $error("pin zero value mismatch");
   AST_PORT_PIN_ONE_DIRECTION: assert property (@(posedge ref_clk) disable iff (rst)
      rstn_s && !io_reg[cvio_pkg::CVIO_SYNC_EN] && io_reg[cvio_pkg::CVIO_PORT_PIN_ONE_DIRECTION]
      && $stable(io_reg) ##1 rstn_s |-> port_pin_one_oe)
      else $error("pin one not driven as output");
   AST_ALIGN_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
      !any_rst |=> align_pulse == ($past(io_reg[cvio_pkg::CVIO_SYNC_EN]) && !$past(p1_s)))
      else $error("align output does not follow pin one");
   AST_WRITE_LANDS: assert property (@(posedge ref_clk) disable iff (rst)
      rise && bit_cnt == 3'h7 && state == cvio_pkg::CVIO_ST_DATA && !cmd_read && !any_rst
      && addr == cvio_pkg::CVIO_ADDR_IOPORT |=> io_reg == $past(done_byte))
      else $error("written byte not in addressed register");
   AST_MCO_OFF: assert property (@(posedge ref_clk) disable iff (rst)
      aux_reg[cvio_pkg::CVIO_MCO_OFF] |=> !master_clock_output)
      else $error("clock output not off");
   AST_MCO_INV: assert property (@(posedge ref_clk) disable iff (rst)
      !aux_reg[cvio_pkg::CVIO_MCO_OFF] |=> master_clock_output == !$past(mclk_s))
      else $error("clock output not inverted");
   AST_DOUT_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
      cs_n_s |=> !serial_data_out)
      else $error("data out active outside frame");
endmodule
`default_nettype wire

// >>> sim/cvio_host.sv
// Purpose: Host serial master model
// Assumes: Serial clock 160 ns, idle high
// Notes: Data line inverted once released
`timescale 1ns/100ps
`default_nettype none
module cvio_host (
   input wire logic ref_clk,
   input wire logic sdo,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   task automatic half();
      repeat (16) @(negedge ref_clk);
   endtask
   // Host owns the clock; it stands high between frames
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         half();
         sclk = 1'b0;
         sdi = tx[i];
         half();
         sclk = 1'b1;
         rx[i] = sdo;
      end
   endtask
   // Select frames each byte unless tied low
   task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input logic tie,
         output logic [7:0] rx);
      logic [7:0] unused;
      cs_n = 1'b0;
      xfer(cmd, unused);
      half();
      cs_n = ~tie;
      half();
      cs_n = 1'b0;
      xfer(dat, rx);
      half();
      cs_n = ~tie;
      sdi = ~sdi;
      // Deselect stands a while before any next frame
      half();
   endtask
   // Partial byte then deselect; device must drop it
   task automatic cut(input logic [3:0] tx);
      cs_n = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         half();
         sclk = 1'b0;
         sdi = tx[i];
         half();
         sclk = 1'b1;
      end
      half();
      cs_n = 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// >>> sim/converter_io_pins_and_reset_test.sv
// Purpose: Pin, reset and serial access checks
// Assumes: Inputs change at falling ref_clk
// Notes: Pin levels resolved from both drivers
`timescale 1ns/100ps
`default_nettype none
module converter_io_pins_and_reset_test;
   logic ref_clk, rst, reset_n, sclk, cs_n, sdi, sdo, mci, mco, p0_drv, p1_drv;
   logic p0_out, p0_oe, p1_out, p1_oe, align_pulse, logic_reset, p0_pin, p1_pin;
   logic [7:0] rx;
   int miscompares = 0;
   int num_checks = 0;
   int n;
   assign p0_pin = p0_oe ? p0_out : p0_drv;
   assign p1_pin = p1_oe ? p1_out : p1_drv;
   cvio_top u_dut (.ref_clk(ref_clk), .rst(rst), .reset_n(reset_n), .serial_clock(sclk),
      .chip_select_n(cs_n), .serial_data_in(sdi), .serial_data_out(sdo),
      .master_clock_input(mci), .master_clock_output(mco), .port_pin_zero_in(p0_pin),
      .port_pin_zero_out(p0_out), .port_pin_zero_oe(p0_oe),
      .align_or_port_pin_one_in(p1_pin), .port_pin_one_out(p1_out),
      .port_pin_one_oe(p1_oe), .align_pulse(align_pulse), .logic_reset(logic_reset));
   cvio_host u_host (.ref_clk(ref_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      mci = 1'b0;
      forever begin
         repeat (2) @(negedge ref_clk);
         mci = ~mci;
      end
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      u_host.frame({5'h00, a}, d, 1'b0, rx);
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic tie);
      u_host.frame({5'h08, a}, 8'h00, tie, rx);
   endtask
   task automatic mco_toggles();
      logic prev;
      n = 0;
      prev = mco;
      repeat (64) begin
         @(negedge ref_clk);
         n += int'(mco !== prev);
         prev = mco;
      end
   endtask
   initial begin
      rst = 1'b1;
      reset_n = 1'b1;
      p0_drv = 1'b1;
      p1_drv = 1'b0;
      repeat (16) @(negedge ref_clk);
      check("in_reset", {4'h0, logic_reset, p0_oe, p1_oe, mco}, 8'h09);
      rst = 1'b0;
      repeat (8) @(negedge ref_clk);
      check("reset_flag", {7'h00, logic_reset}, 8'h00);
      rd(cvio_pkg::CVIO_ADDR_IOPORT, 1'b0);
      check("io_inputs", rx, 8'h80);
      wr(cvio_pkg::CVIO_ADDR_IOPORT, 8'hf0);
      check("pins_out", {4'h0, p0_oe, p0_out, p1_oe, p1_out}, 8'h0f);
      rd(cvio_pkg::CVIO_ADDR_IOPORT, 1'b1);
      check("io_3wire", rx, 8'hf0);
      wr(cvio_pkg::CVIO_ADDR_IOPORT, 8'h51);
      check("sync_low", {6'h00, p1_oe, align_pulse}, 8'h01);
      p1_drv = 1'b1;
      repeat (8) @(negedge ref_clk);
      check("sync_high", {6'h00, p1_oe, align_pulse}, 8'h00);
      rd(3'h5, 1'b0);
      check("unmapped", rx, 8'h00);
      wr(cvio_pkg::CVIO_ADDR_AUX, 8'h01);
      mco_toggles();
      check("mco_off", 8'(n), 8'h00);
      wr(cvio_pkg::CVIO_ADDR_AUX, 8'h00);
      mco_toggles();
      check("mco_on", {7'h00, n > 16}, 8'h01);
      wr(cvio_pkg::CVIO_ADDR_IOPORT, 8'hf0);
      reset_n = 1'b0;
      repeat (8) @(negedge ref_clk);
      check("pin_reset", {5'h00, logic_reset, p0_oe, p1_oe}, 8'h04);
      reset_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      u_host.cut(4'hf);
      rd(cvio_pkg::CVIO_ADDR_IOPORT, 1'b0);
      check("io_cleared", rx, 8'hc0);
      tally_and_finish();
   end
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
